// ### adc_conversion_control_io.sv
// Conversion control, result coding, general-purpose I/O and clock output with APB registers
//
// Function
// - Value 23h routes inputs two and three
// - Ready held high until new result settled
// - Pin low again: ready high until settled
// - Wake from standby starts settled conversion
// - Continuous conversion, ready falls each period once result read
// - Settling periods 5, 3, 2, 1 by rate
// - Result is 24-bit two's complement word
// - Result saturates at 7FFFFFh and 800000h
// - Zero maps to zero, LSB steps exact
// - Each pin follows own direction and value, pin zero only while clock out is off
// - Value bits read actual pin levels
// - Absent pins ignore their control bits
// - Pins stay active in standby, power-down
// - Reset: pins inputs, pin zero clock out
// - Clock out is master, half or quarter
// - Standby leaves the clock output running
//
// The placing of the registers and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "adc_ctrl_defines.svh"
module adc_conversion_control_io #(
  parameter int NUM_GPIO     = 4,                  // 2 for the small variant
  parameter int PERIOD_EDGES = `MASTER_EDGES_30K   // Master edges per period at fastest rate
) (
  // APB slave
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic                    pready,
  output logic [31:0]             prdata,
  output logic                    pslverr,
  // Master clock and control pins
  input  wire logic               master_clk_in,
  input  wire logic               resync_powerdown_pin,
  output logic                    data_ready_n,
  // Analog front end stand-in
  input  wire logic signed [25:0] analog_diff,
  output logic [3:0]              analog_pos_sel,
  output logic [3:0]              analog_neg_sel,
  // General-purpose pins, pin zero doubles as clock out
  input  wire logic [3:0]         gpio_in,
  output logic [3:0]              gpio_out,
  output logic [3:0]              gpio_oe
);

  // Register storage
  logic [7:0]  input_sel_ff;        // Input selection
  logic [1:0]  conv_ctrl_ff;        // Clock-out select field
  logic [1:0]  data_rate_ff;        // 0 fastest .. 3 slowest
  logic [3:0]  gpio_dir_ff;         // 1 = input
  logic [3:0]  gpio_val_ff;         // Output levels
  logic [23:0] result_ff;           // Last coded result
  logic        standby_ff;          // Standby entered by command
  logic        halted_ff;           // Stopped by resync command

  // Synchronisers for outside inputs
  logic [1:0]  mclk_sync_ff;
  logic [1:0]  pdwn_sync_ff;
  logic [3:0]  gpio_s1_ff;
  logic [3:0]  gpio_s2_ff;
  logic signed [25:0] ana_s1_ff;
  logic signed [25:0] ana_s2_ff;
  logic        mclk_prev_ff;        // Reads only the second stage
  logic        pdwn_prev_ff;

  // Conversion engine, ready and bus answer flops
  adc_ctrl_pkg::conv_state_t state_ff;
  logic [15:0] edge_cnt_ff;         // Master edges within current wait
  logic [1:0]  div_ff;              // Clock-out divider
  logic        pready_ff;
  logic [31:0] prdata_ff;
  logic        pslverr_ff;
  logic        data_ready_n_n_ff;

  // Bus strobes, edge detects and wait counts
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        mclk_rise;
  logic        pdwn_fall;
  logic        cmd_valid;
  logic [7:0]  cmd;
  logic [15:0] period_edges;
  logic [15:0] settle_edges;
  logic        restart;
  logic        read_result;

  // Settling periods per data rate
  function automatic logic [2:0] settle_periods(input logic [1:0] rate);
    unique case (rate)
      2'h0:    settle_periods = `SETTLE_30K;
      2'h1:    settle_periods = `SETTLE_15K;
      2'h2:    settle_periods = `SETTLE_7K5;
      default: settle_periods = `SETTLE_SLOW;
    endcase
  endfunction

  // Saturate a wide sample into the 24-bit word
  function automatic logic [23:0] clip24(input logic signed [25:0] s);
    if (s >= `SAMPLE_MAX) begin
      clip24 = `RESULT_MAX;
    end else if (s <= `SAMPLE_MIN) begin
      clip24 = `RESULT_MIN;
    end else begin
      clip24 = s[23:0];
    end
  endfunction

  // Address decode, used for reads, writes and the error answer
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `ADDR_INPUT_SEL) || (a == `ADDR_CONV_CTRL) || (a == `ADDR_DATA_RATE) ||
             (a == `ADDR_GPIO) || (a == `ADDR_COMMAND) || (a == `ADDR_RESULT) ||
             (a == `ADDR_STATUS);
  endfunction

  // One wait state: answer in the second access cycle
  assign access      = psel & penable & pready_ff;
  assign wr_en       = access & pwrite & mapped(paddr);
  assign rd_en       = access & ~pwrite & mapped(paddr);
  assign cmd_valid   = wr_en && (paddr == `ADDR_COMMAND);
  assign cmd         = pwdata[7:0];
  assign mclk_rise   = mclk_sync_ff[1] & ~mclk_prev_ff;
  assign pdwn_fall   = ~pdwn_sync_ff[1] & pdwn_prev_ff;
  // Longer wait counts scale with the rate: each step halves the data rate
  assign period_edges = 16'(PERIOD_EDGES << data_rate_ff);
  assign settle_edges = 16'(period_edges * settle_periods(data_rate_ff));
  // Resync/input change/wake all restart the filter
  assign restart     = pdwn_fall | (cmd_valid && (cmd == `CMD_WAKE)) |
                       (wr_en && (paddr == `ADDR_INPUT_SEL));
  assign read_result = (cmd_valid && (cmd == `CMD_READ_DATA)) ||
                       (rd_en && (paddr == `ADDR_RESULT));

  // Two-flop synchronisers; nothing reads the first stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_sync_ff <= 2'h0;
      pdwn_sync_ff <= 2'h0;
      gpio_s1_ff   <= 4'h0;
      gpio_s2_ff   <= 4'h0;
      ana_s1_ff    <= 26'sh0;
      ana_s2_ff    <= 26'sh0;
      mclk_prev_ff <= 1'b0;
      pdwn_prev_ff <= 1'b0;
    end else begin
      mclk_sync_ff <= {mclk_sync_ff[0], master_clk_in};
      pdwn_sync_ff <= {pdwn_sync_ff[0], resync_powerdown_pin};
      gpio_s1_ff   <= gpio_in;
      gpio_s2_ff   <= gpio_s1_ff;
      ana_s1_ff    <= analog_diff;
      ana_s2_ff    <= ana_s1_ff;
      mclk_prev_ff <= mclk_sync_ff[1];
      pdwn_prev_ff <= pdwn_sync_ff[1];
    end
  end

  // Configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_sel_ff <= `RST_INPUT_SEL;
      conv_ctrl_ff <= `RST_CONV_CTRL;
      data_rate_ff <= `RST_DATA_RATE;
      gpio_dir_ff  <= `RST_GPIO_DIR;
      gpio_val_ff  <= `RST_GPIO_VAL;
    end else if (wr_en) begin
      unique case (paddr)
        `ADDR_INPUT_SEL: input_sel_ff <= pwdata[7:0];
        `ADDR_CONV_CTRL: conv_ctrl_ff <= pwdata[1:0];
        `ADDR_DATA_RATE: data_rate_ff <= pwdata[1:0];
        `ADDR_GPIO: begin
          gpio_dir_ff <= pwdata[`GPIO_DIR_LSB +: 4];
          gpio_val_ff <= pwdata[`GPIO_VAL_LSB +: 4];
        end
        default: ;                      // Command, result and status hold no settings
      endcase
    end
  end

  // Multiplexer routing from the input select register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_pos_sel <= 4'h0;
      analog_neg_sel <= 4'h1;
    end else begin
      analog_pos_sel <= input_sel_ff[7:4];
      analog_neg_sel <= input_sel_ff[3:0];
    end
  end

  // Standby and halt flags from commands; wake clears both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_ff <= 1'b0;
      halted_ff  <= 1'b0;
    end else if (cmd_valid) begin
      unique case (cmd)
        `CMD_STANDBY: standby_ff <= 1'b1;
        `CMD_RESYNC:  halted_ff  <= 1'b1;
        `CMD_WAKE: begin
          standby_ff <= 1'b0;
          halted_ff  <= 1'b0;
        end
        default: ;                      // Read command changes no mode
      endcase
    end
  end

  // Conversion sequencer counted in master clock edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff    <= adc_ctrl_pkg::CONV_SETTLING;
      edge_cnt_ff <= 16'h0;
    end else if (pdwn_sync_ff[1] || standby_ff || halted_ff) begin
      // Filter stopped while pin high, standby or after resync
      state_ff    <= adc_ctrl_pkg::CONV_STOPPED;
      edge_cnt_ff <= 16'h0;
    end else if (restart || state_ff == adc_ctrl_pkg::CONV_STOPPED) begin
      state_ff    <= adc_ctrl_pkg::CONV_SETTLING;
      edge_cnt_ff <= 16'h0;
    end else if (mclk_rise) begin
      unique case (state_ff)
        adc_ctrl_pkg::CONV_SETTLING: begin
          if (edge_cnt_ff == settle_edges - 16'h1) begin
            state_ff    <= adc_ctrl_pkg::CONV_RUNNING;
            edge_cnt_ff <= 16'h0;
          end else begin
            edge_cnt_ff <= edge_cnt_ff + 16'h1;
          end
        end
        default: begin
          // Running: one result each data-ready period
          if (edge_cnt_ff == period_edges - 16'h1) begin
            edge_cnt_ff <= 16'h0;
          end else begin
            edge_cnt_ff <= edge_cnt_ff + 16'h1;
          end
        end
      endcase
    end
  end

  // Completion strobe shared by result and ready
  logic done;
  assign done = mclk_rise && !restart && !pdwn_sync_ff[1] && !standby_ff && !halted_ff &&
                (((state_ff == adc_ctrl_pkg::CONV_SETTLING) &&
                  (edge_cnt_ff == settle_edges - 16'h1)) ||
                 ((state_ff == adc_ctrl_pkg::CONV_RUNNING) &&
                  (edge_cnt_ff == period_edges - 16'h1)));

  // Result capture with saturation; sign carried in two's complement
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ff <= 24'h0;
    end else if (done) begin
      result_ff <= clip24(ana_s2_ff);
    end
  end

  // Ready falls on completion, rises on restart or once the result is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ready_n_n_ff <= 1'b1;
    end else if (done) begin
      data_ready_n_n_ff <= 1'b0;
    end else if (restart || pdwn_sync_ff[1] || halted_ff || read_result) begin
      data_ready_n_n_ff <= 1'b1;
    end
  end
  assign data_ready_n = data_ready_n_n_ff;

  // Clock-out divider on master edges; standby does not touch it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= 2'h0;
    end else if (mclk_rise) begin
      div_ff <= div_ff + 2'h1;
    end
  end

  // Pin drivers, retimed so outputs come from flops; one more pclk of skew
  // on the clock output is the price of that.
  genvar gi;
  generate
    for (gi = 0; gi < `GPIO_PIN_COUNT; gi++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          gpio_out[gi] <= 1'b0;
          gpio_oe[gi]  <= 1'b0;
        end else if (gi >= NUM_GPIO) begin
          gpio_out[gi] <= 1'b0;
          gpio_oe[gi]  <= 1'b0;
        end else if (gi == 0 && conv_ctrl_ff != `CLKOUT_OFF) begin
          gpio_oe[gi] <= 1'b1;
          unique case (conv_ctrl_ff)
            `CLKOUT_DIV1: gpio_out[gi] <= mclk_sync_ff[1];
            `CLKOUT_DIV2: gpio_out[gi] <= div_ff[0];
            default:      gpio_out[gi] <= div_ff[1];
          endcase
        end else begin
          gpio_out[gi] <= gpio_val_ff[gi];
          gpio_oe[gi]  <= ~gpio_dir_ff[gi];
        end
      end
    end
  endgenerate

  // APB answer: one wait state, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel & penable & ~pready_ff;
      pslverr_ff <= psel & penable & ~pready_ff & ~mapped(paddr);
      prdata_ff  <= 32'h0;
      if (psel && penable && !pready_ff && !pwrite) begin
        unique case (paddr)
          `ADDR_INPUT_SEL: prdata_ff <= {24'h0, input_sel_ff};
          `ADDR_CONV_CTRL: prdata_ff <= {30'h0, conv_ctrl_ff};
          `ADDR_DATA_RATE: prdata_ff <= {30'h0, data_rate_ff};
          // Value bits show the pin itself, whatever the direction
          `ADDR_GPIO:      prdata_ff <= {24'h0, gpio_s2_ff, gpio_dir_ff};
          `ADDR_RESULT:    prdata_ff <= {8'h0, result_ff};
          `ADDR_STATUS:    prdata_ff <= {27'h0, state_ff, halted_ff, standby_ff, data_ready_n_n_ff};
          default:         prdata_ff <= 32'h0;
        endcase
      end
    end
  end
  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

endmodule

// ### adc_ctrl_defines.svh
// Register map, field positions, reset values and timing counts of the converter control block
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
`define ADDR_INPUT_SEL      8'h00
`define ADDR_CONV_CTRL      8'h04
`define ADDR_DATA_RATE      8'h08
`define ADDR_GPIO           8'h0C
`define ADDR_COMMAND        8'h10
`define ADDR_RESULT         8'h14
`define ADDR_STATUS         8'h18
`define RST_INPUT_SEL       8'h01
`define RST_CONV_CTRL       2'h1
`define RST_DATA_RATE       2'h0
`define RST_GPIO_DIR        4'hF
`define RST_GPIO_VAL        4'h0
`define CMD_RESYNC          8'h01
`define CMD_WAKE            8'h02
`define CMD_STANDBY         8'h03
`define CMD_READ_DATA       8'h04
`define CLKOUT_OFF          2'h0
`define CLKOUT_DIV1         2'h1
`define CLKOUT_DIV2         2'h2
`define CLKOUT_DIV4         2'h3
`define GPIO_DIR_LSB        0
`define GPIO_VAL_LSB        4
`define GPIO_PIN_COUNT      4
`define RESULT_MAX          24'h7FFFFF
`define RESULT_MIN          24'h800000
`define SAMPLE_MAX          26'sh07FFFFF
`define SAMPLE_MIN          -26'sh0800000
`define MASTER_EDGES_30K    256
`define SETTLE_30K          3'h5
`define SETTLE_15K          3'h3
`define SETTLE_7K5          3'h2
`define SETTLE_SLOW         3'h1
`endif

// ### adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    CONV_STOPPED,
    CONV_SETTLING,
    CONV_RUNNING
  } conv_state_t;
endpackage

// ### adc_ctrl_props.sv
// Port assertions for the converter control block
`timescale 1ns/1ps
module adc_ctrl_props #(
  parameter int NUM_GPIO     = 4,
  parameter int PERIOD_EDGES = 256
) (
  // Bus side
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pready,
  input wire logic [31:0]       prdata,
  input wire logic              pslverr,
  // Pin side
  input wire logic              master_clk_in,
  input wire logic              resync_powerdown_pin,
  input wire logic              data_ready_n,
  input wire logic signed [25:0] analog_diff,
  input wire logic [3:0]        analog_pos_sel,
  input wire logic [3:0]        analog_neg_sel,
  input wire logic [3:0]        gpio_in,
  input wire logic [3:0]        gpio_out,
  input wire logic [3:0]        gpio_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed transfer
  wire done = psel && penable && pready;
  // Exactly one wait state
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready late");
  apb_pulse_a: assert property (pready |=> !pready)
    else $error("pready held");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not idle");
  sel_route_a:
    assert property (done && pwrite && paddr == 8'h00 |->
      ##2 {analog_pos_sel, analog_neg_sel} == 8'($past(pwdata, 2)))
    else $error("input select mismatch");
  gpio_dir_a:
    assert property (done && pwrite && paddr == 8'h0C |->
      ##2 ~gpio_oe[3:1] == (3'($past(pwdata, 2) >> 1) | 3'(~((1 << (NUM_GPIO - 1)) - 1))))
    else $error("pin direction mismatch");
  // Synchroniser gives three cycles of slack
  pin_hold_a:
    assert property (resync_powerdown_pin [*4] |-> data_ready_n)
    else $error("ready low while stopped");
  wake_hold_a:
    assert property (done && pwrite && paddr == 8'h10 && pwdata[7:0] == 8'h02 |->
      ##2 data_ready_n [*8])
    else $error("ready low before settling");
  result_width_a:
    assert property (done && !pwrite && paddr == 8'h14 |-> prdata[31:24] == 8'h00)
    else $error("result wider than 24 bits");
endmodule
bind adc_conversion_control_io adc_ctrl_props #(
  .NUM_GPIO(NUM_GPIO), .PERIOD_EDGES(PERIOD_EDGES)
) adc_ctrl_props_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .master_clk_in(master_clk_in),
  .resync_powerdown_pin(resync_powerdown_pin), .data_ready_n(data_ready_n),
  .analog_diff(analog_diff), .analog_pos_sel(analog_pos_sel),
  .analog_neg_sel(analog_neg_sel), .gpio_in(gpio_in), .gpio_out(gpio_out),
  .gpio_oe(gpio_oe));

// ### adc_pin_env.sv
// Pin environment: free master clock and resolved general-purpose pins
`timescale 1ns/1ps
module adc_pin_env (
  // Block pins
  output logic             master_clk_in,
  input  wire logic [3:0]  gpio_out,
  input  wire logic [3:0]  gpio_oe,
  output logic [3:0]       gpio_in,
  // Outside drive for pins left as inputs
  input  wire logic [3:0]  ext_level
);
  // Odd offset keeps master edges off the bus clock edges
  initial begin
    master_clk_in = 1'b0;
    #137;
    forever #400 master_clk_in = ~master_clk_in;
  end
  // Wire level comes from whoever enables a driver
  always_comb begin
    for (int i = 0; i < 4; i++) gpio_in[i] = gpio_oe[i] ? gpio_out[i] : ext_level[i];
  end
endmodule

// ### adc_conversion_control_io_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
module adc_conversion_control_io_tb_top;
  localparam int PE = 4;          // Shortened period in master edges
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, master_clk_in, data_ready_n, err;
  logic        resync_powerdown_pin = 1'b0;
  logic signed [25:0] analog_diff = 26'sh0;
  logic [3:0]  analog_pos_sel, analog_neg_sel, gpio_in, gpio_out, gpio_oe;
  logic [3:0]  ext_level = 4'h0;  // Outside pin drive
  logic [3:0]  small_oe, small_out;  // Two-pin variant drivers
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cyc = 0;           // Bus cycle count
  always #50 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  adc_conversion_control_io #(.NUM_GPIO(4), .PERIOD_EDGES(PE)) adc_conversion_control_io_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .master_clk_in(master_clk_in), .resync_powerdown_pin(resync_powerdown_pin),
    .data_ready_n(data_ready_n), .analog_diff(analog_diff),
    .analog_pos_sel(analog_pos_sel), .analog_neg_sel(analog_neg_sel),
    .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe));
  // Two-pin variant on the same bus; only its pin drivers are judged
  adc_conversion_control_io #(.NUM_GPIO(2), .PERIOD_EDGES(PE)) adc_conversion_control_io_two_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(), .prdata(), .pslverr(),
    .master_clk_in(master_clk_in), .resync_powerdown_pin(resync_powerdown_pin),
    .data_ready_n(), .analog_diff(analog_diff), .analog_pos_sel(), .analog_neg_sel(),
    .gpio_in(gpio_in), .gpio_out(small_out), .gpio_oe(small_oe));
  adc_pin_env adc_pin_env_i (.master_clk_in(master_clk_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .gpio_in(gpio_in), .ext_level(ext_level));
  // One bus transfer; answer taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Timing and counts judged within a window
  task automatic chk_rng(input int n, input int lo, input int hi);
    cmp_count++;
    if (n < lo || n > hi) begin
      miscompares++;
      $display("[ERR] %0t count %0d not in %0d..%0d", $time, n, lo, hi);
    end
  endtask
  // Bounded wait for ready to go low
  task automatic wait_rdy(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while ((n < 3 || data_ready_n !== 1'b0) && n < 3000);
  endtask
  task automatic count_rise(input int cycles, output int k);
    logic last;
    k = 0;
    last = gpio_out[0];
    repeat (cycles) begin
      @(negedge pclk);
      if (gpio_out[0] && !last) k++;
      last = gpio_out[0];
    end
  endtask
  task automatic t_reset;
    chk(gpio_oe, 32'h1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd[3:0], 32'hF);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h1);
    apb(1'b0, 8'h1C, 32'h0);
    chk(err, 32'h1);
  endtask
  task automatic t_mux;
    apb(1'b1, 8'h00, 32'h23);
    repeat (2) @(negedge pclk);
    chk({analog_pos_sel, analog_neg_sel}, 32'h23);
    apb(1'b1, 8'h00, 32'h5C);
    repeat (2) @(negedge pclk);
    chk({analog_pos_sel, analog_neg_sel}, 32'h5C);
  endtask
  // Settling then period at every rate, restarted by resync then wake commands
  task automatic t_rates;
    int n;
    int t0;
    int st [4] = '{5, 3, 2, 1};
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, 8'h08, 32'(r));
      apb(1'b1, 8'h00, 32'h23);
      apb(1'b1, 8'h10, 32'h01);
      apb(1'b1, 8'h10, 32'h02);
      wait_rdy(n);
      chk_rng(n, st[r] * (PE << r) * 8 - 8, st[r] * (PE << r) * 8 + 12);
      t0 = cyc;
      apb(1'b0, 8'h14, 32'h0);
      wait_rdy(n);
      chk_rng(cyc - t0, (PE << r) * 8 - 1, (PE << r) * 8 + 1);
    end
  endtask
  task automatic t_codes;
    logic signed [25:0] a [7] = '{26'sh0, 26'sh1, -26'sh1, 26'sh07FFFFF, 26'sh1000000,
                                  -26'sh0800000, -26'sh0800001};
    logic [23:0] e [7] = '{24'h000000, 24'h000001, 24'hFFFFFF, 24'h7FFFFF, 24'h7FFFFF,
                           24'h800000, 24'h800000};
    int n;
    apb(1'b1, 8'h08, 32'h0);
    for (int i = 0; i < 7; i++) begin
      analog_diff <= a[i];
      apb(1'b1, 8'h10, 32'h02);
      wait_rdy(n);
      apb(1'b0, 8'h14, 32'h0);
      chk(rd, {8'h00, e[i]});
    end
  endtask
  task automatic t_pin;
    int n;
    @(posedge pclk);
    resync_powerdown_pin <= 1'b1;
    repeat (40) @(negedge pclk);
    chk(data_ready_n, 32'h1);
    @(posedge pclk);
    resync_powerdown_pin <= 1'b0;
    wait_rdy(n);
    chk_rng(n, 150, 185);
  endtask
  // Standby keeps pins and clock out alive, wake gives one result
  task automatic t_standby;
    int n;
    apb(1'b1, 8'h0C, 32'hA1);
    apb(1'b1, 8'h10, 32'h03);
    apb(1'b0, 8'h14, 32'h0);
    count_rise(80, n);
    chk_rng(n, 9, 11);
    chk({gpio_oe[3:1], gpio_out[3:1]}, 32'h3D);
    chk(data_ready_n, 32'h1);
    apb(1'b1, 8'h10, 32'h02);
    wait_rdy(n);
    chk_rng(n, 150, 185);
    apb(1'b0, 8'h14, 32'h0);
    apb(1'b1, 8'h10, 32'h03);
  endtask
  task automatic t_clk;
    int n;
    for (int s = 3; s >= 0; s--) begin
      apb(1'b1, 8'h04, 32'(s));
      repeat (16) @(negedge pclk);
      count_rise(320, n);
      chk_rng(n, s ? (80 >> s) - 1 : 0, s ? (80 >> s) + 1 : 0);
    end
  endtask
  task automatic t_gpio;
    apb(1'b1, 8'h0C, 32'h50);
    repeat (4) @(negedge pclk);
    chk({gpio_oe, gpio_out}, 32'hF5);
    chk({small_oe, small_out}, 32'h31);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd[7:4], 32'h5);
    @(posedge pclk);
    ext_level <= 4'hA;
    apb(1'b1, 8'h0C, 32'h0F);
    repeat (4) @(negedge pclk);
    chk(gpio_oe, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd[7:4], 32'hA);
  endtask
  task automatic summarize;
    if (miscompares == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(negedge pclk);
    t_reset();
    t_mux();
    t_rates();
    t_codes();
    t_pin();
    t_standby();
    t_clk();
    t_gpio();
    summarize();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    summarize();
  end
endmodule
